// >>> verilog/cud_pkg.sv
// Constants, register layout and configuration type of the up/down counter bank.
// Assumes a 200 MHz clock and a plain register port with one-cycle strobes.
package cud_pkg;
   localparam int NUM_CNT = 8;
   localparam int VAL_W   = 16;
   localparam int NUM_SIG = 32;
   localparam int SEL_W   = 5;
   localparam int MODE_W  = 3;
   localparam int ADDR_W  = 6;
   localparam int DATA_W  = 32;
   localparam int CLK_NS  = 5;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam int TICK_W  = 18;

   localparam logic [2:0] REG_SEL  = 3'h0;
   localparam logic [2:0] REG_LIM  = 3'h1;
   localparam logic [2:0] REG_STEP = 3'h2;
   localparam logic [2:0] REG_TIME = 3'h3;
   localparam logic [2:0] REG_FLAG = 3'h4;
   localparam logic [2:0] REG_STAT = 3'h5;

   localparam int F_UP   = 0;
   localparam int F_DN   = 8;
   localparam int F_CLR  = 16;
   localparam int F_MODE = 24;
   localparam int F_LO   = 0;
   localparam int F_HI   = 16;
   localparam int S_LOAD  = 16;
   localparam int S_ABOVE = 17;
   localparam int S_DESC  = 18;

   localparam logic [2:0] M_HIGH = 3'h0;
   localparam logic [2:0] M_LOW  = 3'h1;
   localparam logic [2:0] M_RISE = 3'h2;
   localparam logic [2:0] M_FALL = 3'h3;
   localparam logic [2:0] M_CHG  = 3'h4;
   localparam logic [2:0] M_TOG  = 3'h5;

   localparam logic [15:0] RST_MIN  = 16'h0000;
   localparam logic [15:0] RST_MAX  = 16'hffff;
   localparam logic [15:0] RST_STEP = 16'h0001;
   localparam logic [15:0] RST_TIME = 16'h0000;
   localparam logic [15:0] RST_FLAG = 16'h0000;

   typedef struct packed {
      logic [MODE_W-1:0] mode;
      logic [SEL_W-1:0]  sel_up;
      logic [SEL_W-1:0]  sel_dn;
      logic [SEL_W-1:0]  sel_clr;
      logic [VAL_W-1:0]  min;
      logic [VAL_W-1:0]  max;
      logic [VAL_W-1:0]  tap_step;
      logic [VAL_W-1:0]  rep_step;
      logic [VAL_W-1:0]  hold_ms;
      logic [VAL_W-1:0]  rep_ms;
      logic [VAL_W-1:0]  flag;
   } cud_cfg_t;

   localparam cud_cfg_t CFG_RST = '{M_HIGH, 5'h00, 5'h00, 5'h00, RST_MIN, RST_MAX,
                                    RST_STEP, RST_STEP, RST_TIME, RST_TIME, RST_FLAG};

   // Everything one counter remembers lives in this one register.
   typedef struct packed {
      logic             prev_up;
      logic             prev_dn;
      logic             held;
      logic             long_p;
      logic             load;
      logic             desc;
      logic             above;
      logic [VAL_W-1:0] press;
      logic [VAL_W-1:0] rep;
      logic [VAL_W-1:0] val;
   } cud_ch_t;

   typedef struct packed {
      cud_cfg_t [NUM_CNT-1:0] cfg;
      logic [TICK_W-1:0]      tick;
      logic [DATA_W-1:0]      rdata;
   } cud_top_t;

   localparam cud_top_t TOP_RST = '{{NUM_CNT{CFG_RST}}, '0, '0};
endpackage

// >>> verilog/cud_top.sv
// Bank of eight up/down counters with register port, one counter module per element.
// Assumes SIGNALS come from logic on CLOCK; bit 0 is expected tied low as "none".
// Notes on behaviour
// [R01] Eight independent counters, each with own selects, mode, limits, steps, times, flag.
// [R02] A selectable up source makes the value rise.
// [R03] A selectable down source makes the value fall.
// [R04] A selectable clear source high loads the lower limit.
// [R05] Level-high mode steps while the source is high.
// [R06] Level-low mode steps while the source is low.
// [R07] Rising-edge mode steps once per low-to-high transition.
// [R08] Falling-edge mode steps once per high-to-low transition.
// [R09] Change mode steps once per transition either way.
// [R10] Toggle-and-ramp mode uses only the up source; down is ignored.
// [R11] A short pulse switches the load on; the next short one switches it off.
// [R12] Ascending, each long pulse raises the value until the upper limit.
// [R13] At the upper limit, long pulses lower the value until the lower limit.
// [R14] Reaching either limit reverses the ramp direction.
// [R15] The value never goes below the lower limit.
// [R16] The value never exceeds the upper limit unless the lower limit is set above it.
// [R17] In level modes a first press changes the value by the tap step.
// [R18] Level modes: after the hold time, step by the repeat step, then each interval.
// [R19] Edge modes step by the repeat step on each qualifying edge.
// [R20] Level modes repeat the held step once per repeat interval.
// [R21] A source counts as held only after staying active for the hold time.
// [R22] The above flag is high exactly when the value exceeds the flag level.
// [R23] Steps past a limit saturate at the limit.
// [R24] Clear beats a step in the same cycle.

module cud_chan (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             tick,
   input  wire logic             up_src,
   input  wire logic             dn_src,
   input  wire logic             clr_src,
   input  wire cud_pkg::cud_cfg_t cfg,
   output logic [15:0]           value,
   output logic                  load_on,
   output logic                  above,
   output logic                  desc
);
   cud_pkg::cud_ch_t s;
   cud_pkg::cud_ch_t n;
   logic             au;
   logic             ad;
   logic             pau;
   logic             pad;
   logic             inc;
   logic             dec;
   logic [15:0]      stp;
   logic [16:0]      sum;
   logic [15:0]      nv;

   // Level-low mode simply inverts the sense of both sources.
   assign au  = (cfg.mode == cud_pkg::M_LOW) ? ~up_src : up_src;
   assign ad  = (cfg.mode == cud_pkg::M_LOW) ? ~dn_src : dn_src;
   assign pau = (cfg.mode == cud_pkg::M_LOW) ? ~s.prev_up : s.prev_up;
   assign pad = (cfg.mode == cud_pkg::M_LOW) ? ~s.prev_dn : s.prev_dn;

   always_comb
   begin
      n = s;
      n.prev_up = up_src;
      n.prev_dn = dn_src;
      inc = 1'b0;
      dec = 1'b0;
      stp = cfg.rep_step;
      nv = s.val;
      case (cfg.mode)
         cud_pkg::M_HIGH, cud_pkg::M_LOW:
         begin
            if ((au | ad) && !(pau | pad))
            begin
               inc = au; // R05
               dec = ~au; // R06
               stp = cfg.tap_step; // R17
               n.press = '0;
               n.held = 1'b0;
            end
            else if (au | ad)
            begin
               if (!s.held)
               begin
                  if (s.press >= cfg.hold_ms)
                  begin
                     inc = au; // R21
                     dec = ~au; // R18
                     n.held = 1'b1;
                     n.rep = '0;
                  end
                  else if (tick)
                     n.press = s.press + 16'h0001;
               end
               else if (s.rep >= cfg.rep_ms)
               begin
                  inc = au; // R20
                  dec = ~au;
                  n.rep = '0;
               end
               else if (tick)
                  n.rep = s.rep + 16'h0001;
            end
            else
            begin
               // Forgetting the count on release stops a mode change from inheriting a stale hold.
               n.held = 1'b0;
               n.press = '0;
            end
         end
         cud_pkg::M_RISE:
         begin
            inc = up_src & ~s.prev_up; // R07
            dec = dn_src & ~s.prev_dn & ~inc; // R19
         end
         cud_pkg::M_FALL:
         begin
            inc = ~up_src & s.prev_up; // R08
            dec = ~dn_src & s.prev_dn & ~inc;
         end
         cud_pkg::M_CHG:
         begin
            inc = up_src ^ s.prev_up; // R09
            dec = (dn_src ^ s.prev_dn) & ~inc;
         end
         cud_pkg::M_TOG:
         begin
            // The down source is never looked at here.
            if (up_src && !s.prev_up) // R10
            begin
               n.press = '0;
               n.long_p = 1'b0;
            end
            else if (up_src && !s.long_p)
            begin
               if (s.press >= cfg.hold_ms)
               begin
                  n.long_p = 1'b1;
                  inc = ~s.desc; // R12
                  dec = s.desc; // R13
               end
               else if (tick)
                  n.press = s.press + 16'h0001;
            end
            else if (!up_src && s.prev_up && !s.long_p)
               n.load = ~s.load; // R11
         end
         default:
            inc = 1'b0;
      endcase
      // The sum is formed once the step is chosen, so the process never reads back its own output.
      sum = {1'b0, s.val} + {1'b0, stp};
      if (inc)
         nv = (sum > {1'b0, cfg.max}) ? cfg.max : sum[15:0]; // R23
      else if (dec)
         nv = ({1'b0, s.val} < {1'b0, cfg.min} + {1'b0, stp}) ? cfg.min : s.val - stp;
      // Clamping every cycle keeps the value legal even when software moves a limit.
      if (nv > cfg.max)
         nv = cfg.max; // R16
      if (nv < cfg.min)
         nv = cfg.min; // R15
      if (clr_src)
         nv = cfg.min; // R04 R24
      if (cfg.mode == cud_pkg::M_TOG && (inc | dec))
      begin
         if (nv >= cfg.max)
            n.desc = 1'b1; // R14
         else if (nv <= cfg.min)
            n.desc = 1'b0;
      end
      n.val = nv;
      n.above = nv > cfg.flag; // R22
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= n;
   end

   assign value = s.val;
   assign load_on = s.load;
   assign above = s.above;
   assign desc = s.desc;

   logic room_up;
   logic room_dn;
   logic room_tap;
   assign room_up = ({1'b0, s.val} + {1'b0, cfg.rep_step} <= {1'b0, cfg.max}) && (s.val >= cfg.min);
   assign room_dn = ({1'b0, s.val} >= {1'b0, cfg.min} + {1'b0, cfg.rep_step}) && (s.val <= cfg.max);
   assign room_tap = ({1'b0, s.val} + {1'b0, cfg.tap_step} <= {1'b0, cfg.max}) && (s.val >= cfg.min);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence lvl_press;
      (cfg.mode == cud_pkg::M_HIGH) && up_src && !s.prev_up && !s.prev_dn && !clr_src;
   endsequence
   sequence lvl_repeat;
      (cfg.mode == cud_pkg::M_HIGH) && up_src && s.prev_up && s.held && (s.rep >= cfg.rep_ms) && !clr_src;
   endsequence
   sequence tog_long;
      (cfg.mode == cud_pkg::M_TOG) && up_src && s.prev_up && !s.long_p && (s.press >= cfg.hold_ms)
         && !s.desc && !clr_src;
   endsequence

   tap_step_a: assert property (lvl_press ##0 room_tap |=> s.val == $past(s.val) + $past(cfg.tap_step)) // R17
      else $error("Tap press did not add the tap step.");
   held_step_a: assert property (lvl_repeat ##0 room_up |=> s.val == $past(s.val) + $past(cfg.rep_step)) // R20
      else $error("Held repeat did not add the repeat step.");
   ramp_up_a: assert property (tog_long ##0 room_up |=> s.long_p && s.val == $past(s.val) + $past(cfg.rep_step)) // R12
      else $error("Long pulse did not ramp upward.");
   low_limit_a: assert property (cfg.min <= cfg.max |=> s.val >= $past(cfg.min)) // R15
      else $error("Value below lower limit.");
   high_limit_a: assert property (cfg.min <= cfg.max |=> s.val <= $past(cfg.max)) // R16
      else $error("Value above upper limit.");
   clear_load_a: assert property (clr_src && cfg.min <= cfg.max |=> s.val == $past(cfg.min)) // R04
      else $error("Clear did not load the lower limit.");
   clear_prio_a: assert property (clr_src && up_src && !s.prev_up && cfg.mode == cud_pkg::M_RISE
                                  |=> s.val == $past(cfg.min) || $past(cfg.min) > $past(cfg.max)) // R24
      else $error("Step beat the clear.");
   above_flag_a: assert property (1'b1 |=> s.above == (s.val > $past(cfg.flag))) // R22
      else $error("Above flag disagrees with value.");
   rise_step_a: assert property (cfg.mode == cud_pkg::M_RISE && up_src && !s.prev_up && !clr_src && room_up
                                 |=> s.val == $past(s.val) + $past(cfg.rep_step)) // R07
      else $error("Rising edge step wrong.");
   fall_step_a: assert property (cfg.mode == cud_pkg::M_FALL && !dn_src && s.prev_dn && !(s.prev_up && !up_src)
                                 && !clr_src && room_dn |=> s.val == $past(s.val) - $past(cfg.rep_step)) // R08
      else $error("Falling edge step wrong.");
   change_step_a: assert property (cfg.mode == cud_pkg::M_CHG && up_src != s.prev_up && !clr_src && room_up
                                   |=> s.val == $past(s.val) + $past(cfg.rep_step)) // R09
      else $error("Change step wrong.");
   tog_ignore_a: assert property (cfg.mode == cud_pkg::M_TOG && !up_src && !s.prev_up && !clr_src
                                  && s.val >= cfg.min && s.val <= cfg.max |=> $stable(s.val)) // R10
      else $error("Ramp value moved without the up source.");
   tog_short_a: assert property (cfg.mode == cud_pkg::M_TOG && !up_src && s.prev_up && !s.long_p
                                 |=> s.load != $past(s.load)) // R11
      else $error("Short pulse did not toggle the load.");
endmodule

module cud_top #(
   parameter int TICK_CYCLES = cud_pkg::TICK_CYC
) (
   input  wire logic                        CLOCK,
   input  wire logic                        RST_N,
   input  wire logic [cud_pkg::ADDR_W-1:0]  ADDR,
   input  wire logic [cud_pkg::DATA_W-1:0]  WDATA,
   input  wire logic                        WR,
   input  wire logic                        RD,
   output logic      [cud_pkg::DATA_W-1:0]  RDATA,
   input  wire logic [cud_pkg::NUM_SIG-1:0] SIGNALS,
   output logic      [cud_pkg::NUM_CNT-1:0] ABOVE,
   output logic      [cud_pkg::NUM_CNT-1:0] LOAD_ON
);
   localparam logic [cud_pkg::TICK_W-1:0] TICK_LAST = cud_pkg::TICK_W'(TICK_CYCLES - 1);

   cud_pkg::cud_top_t         s;
   cud_pkg::cud_top_t         n;
   logic                      tick;
   logic [2:0]                ch;
   logic [cud_pkg::VAL_W-1:0] val_w [cud_pkg::NUM_CNT];
   logic [cud_pkg::NUM_CNT-1:0] desc_w;

   assign ch = ADDR[5:3];
   // Timing fields count in milliseconds, so one shared tick serves all counters.
   assign tick = s.tick == TICK_LAST;

   always_comb
   begin
      n = s;
      n.rdata = '0;
      n.tick = tick ? '0 : s.tick + 1'b1;
      if (WR)
      begin
         case (ADDR[2:0])
            cud_pkg::REG_SEL:
            begin
               n.cfg[ch].sel_up = WDATA[cud_pkg::F_UP +: cud_pkg::SEL_W]; // R02
               n.cfg[ch].sel_dn = WDATA[cud_pkg::F_DN +: cud_pkg::SEL_W]; // R03
               n.cfg[ch].sel_clr = WDATA[cud_pkg::F_CLR +: cud_pkg::SEL_W];
               n.cfg[ch].mode = WDATA[cud_pkg::F_MODE +: cud_pkg::MODE_W];
            end
            cud_pkg::REG_LIM:
            begin
               n.cfg[ch].min = WDATA[cud_pkg::F_LO +: cud_pkg::VAL_W];
               n.cfg[ch].max = WDATA[cud_pkg::F_HI +: cud_pkg::VAL_W];
            end
            cud_pkg::REG_STEP:
            begin
               n.cfg[ch].tap_step = WDATA[cud_pkg::F_LO +: cud_pkg::VAL_W];
               n.cfg[ch].rep_step = WDATA[cud_pkg::F_HI +: cud_pkg::VAL_W];
            end
            cud_pkg::REG_TIME:
            begin
               n.cfg[ch].hold_ms = WDATA[cud_pkg::F_LO +: cud_pkg::VAL_W];
               n.cfg[ch].rep_ms = WDATA[cud_pkg::F_HI +: cud_pkg::VAL_W];
            end
            cud_pkg::REG_FLAG:
               n.cfg[ch].flag = WDATA[cud_pkg::F_LO +: cud_pkg::VAL_W];
            default:
               n.rdata = '0;
         endcase
      end
      if (RD)
      begin
         case (ADDR[2:0])
            cud_pkg::REG_SEL:
            begin
               n.rdata[cud_pkg::F_UP +: cud_pkg::SEL_W] = s.cfg[ch].sel_up;
               n.rdata[cud_pkg::F_DN +: cud_pkg::SEL_W] = s.cfg[ch].sel_dn;
               n.rdata[cud_pkg::F_CLR +: cud_pkg::SEL_W] = s.cfg[ch].sel_clr;
               n.rdata[cud_pkg::F_MODE +: cud_pkg::MODE_W] = s.cfg[ch].mode;
            end
            cud_pkg::REG_LIM:
               n.rdata = {s.cfg[ch].max, s.cfg[ch].min};
            cud_pkg::REG_STEP:
               n.rdata = {s.cfg[ch].rep_step, s.cfg[ch].tap_step};
            cud_pkg::REG_TIME:
               n.rdata = {s.cfg[ch].rep_ms, s.cfg[ch].hold_ms};
            cud_pkg::REG_FLAG:
               n.rdata[cud_pkg::F_LO +: cud_pkg::VAL_W] = s.cfg[ch].flag;
            cud_pkg::REG_STAT:
            begin
               n.rdata[cud_pkg::F_LO +: cud_pkg::VAL_W] = val_w[ch];
               n.rdata[cud_pkg::S_LOAD] = LOAD_ON[ch];
               n.rdata[cud_pkg::S_ABOVE] = ABOVE[ch];
               n.rdata[cud_pkg::S_DESC] = desc_w[ch];
            end
            default:
               n.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
         s <= cud_pkg::TOP_RST;
      else
         s <= n;
   end

   assign RDATA = s.rdata;

   for (genvar g = 0; g < cud_pkg::NUM_CNT; g++)
   begin : g_ch
      cud_chan u_ch ( // R01
         .clk     (CLOCK),
         .rst_n   (RST_N),
         .tick    (tick),
         .up_src  (SIGNALS[s.cfg[g].sel_up]),
         .dn_src  (SIGNALS[s.cfg[g].sel_dn]),
         .clr_src (SIGNALS[s.cfg[g].sel_clr]),
         .cfg     (s.cfg[g]),
         .value   (val_w[g]),
         .load_on (LOAD_ON[g]),
         .above   (ABOVE[g]),
         .desc    (desc_w[g])
      );
   end
endmodule

// >>> verif/cud_sig_model.sv
// Model of the internal binary signals that feed the counter bank.
// Assumes the bench asks for one bit change at a time, on the same clock as the bank.
module cud_sig_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [4:0]  set_idx,
   input  wire logic        set_val,
   input  wire logic        set_we,
   output logic      [31:0] sig
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bit 0 stays low so that select value 0 reads as no source at all.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sig <= 32'h0;
      end
      else if (set_we && set_idx != 5'h0)
      begin
         sig[set_idx] <= set_val;
      end
   end
endmodule

// >>> verif/cud_top_test.sv
// Self-checking bench of the up/down counter bank: register tasks and signal pulses.
// Assumes the bank's register port and a shortened tick of four clock cycles.
module cud_top_test;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int TK = 4;

   logic        clock;
   logic        rst_n;
   logic        wr;
   logic        rd;
   logic        s_we;
   logic        s_val;
   logic [4:0]  s_idx;
   logic [5:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] sig;
   logic [31:0] d;
   logic [7:0]  above;
   logic [7:0]  load_on;
   int          num_errors;
   int          n_tests;
   int          cyc;
   int          ev[8]  = '{1, 1, 1, 2, 2, 2, 1, 3};
   logic [15:0] ex[8]  = '{16'h0005, 16'h0008, 16'h000a, 16'h0007, 16'h0004, 16'h0002, 16'h0005, 16'h0002};
   logic        abv[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
   logic [2:0]  md[3]  = '{cud_pkg::M_RISE, cud_pkg::M_FALL, cud_pkg::M_CHG};
   logic [15:0] mid[3] = '{16'h0005, 16'h0002, 16'h0005};
   logic [15:0] fin[3] = '{16'h0005, 16'h0005, 16'h0008};
   logic [15:0] tv[5]  = '{16'h0002, 16'h0004, 16'h0002, 16'h0000, 16'h0002};
   logic        tdir[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

`define CHK(nm, ex_v, got) begin n_tests++; if ((got) !== (ex_v)) begin \
   $display("[ERR] %s expected %h seen %h", nm, ex_v, got); num_errors++; end end

   cud_top #(
      .TICK_CYCLES (TK)
   ) i_cud_top (
      .CLOCK   (clock),
      .RST_N   (rst_n),
      .ADDR    (addr),
      .WDATA   (wdata),
      .WR      (wr),
      .RD      (rd),
      .RDATA   (rdata),
      .SIGNALS (sig),
      .ABOVE   (above),
      .LOAD_ON (load_on)
   );

   cud_sig_model i_cud_sig_model (
      .clk     (clock),
      .rst_n   (rst_n),
      .set_idx (s_idx),
      .set_val (s_val),
      .set_we  (s_we),
      .sig     (sig)
   );

   function automatic logic [31:0] sel_w(input logic [2:0] m, input logic [4:0] u, input logic [4:0] dn,
                                         input logic [4:0] c);
      return {5'h00, m, 3'h0, c, 3'h0, dn, 3'h0, u};
   endfunction

   task automatic wr_reg(input int c, input logic [2:0] r, input logic [31:0] v);
      @(posedge clock);
      wr <= 1'b1;
      addr <= {3'(c), r};
      wdata <= v;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
   task automatic rd_reg(input int c, input logic [2:0] r, output logic [31:0] v);
      @(posedge clock);
      rd <= 1'b1;
      addr <= {3'(c), r};
      @(posedge clock);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic chk_val(input int c, input logic [15:0] e);
      rd_reg(c, cud_pkg::REG_STAT, d);
      `CHK("value", e, d[15:0])
   endtask

   task automatic sg(input int idx, input logic v);
      @(posedge clock);
      s_we <= 1'b1;
      s_idx <= 5'(idx);
      s_val <= v;
      @(posedge clock);
      s_we <= 1'b0;
      repeat (2) @(posedge clock);
   endtask

   task automatic pulse(input int idx, input int n);
      sg(idx, 1'b1);
      repeat (n) @(posedge clock);
      sg(idx, 1'b0);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // The whole run needs well under two thousand cycles; a hang is cut off here.
   initial
   begin
      cyc = 0;
      forever
      begin
         @(posedge clock);
         cyc++;
         if (cyc == 5000)
         begin
            num_errors++;
            results();
         end
      end
   end

   initial
   begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 6'h00;
      wdata = 32'h0;
      s_we = 1'b0;
      s_idx = 5'h00;
      s_val = 1'b0;
      num_errors = 0;
      n_tests = 0;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      rd_reg(0, cud_pkg::REG_LIM, d);
      `CHK("limits at reset", 32'hffff0000, d)
      rd_reg(0, cud_pkg::REG_STEP, d);
      `CHK("steps at reset", 32'h00010001, d)
      rd_reg(0, 3'h6, d);
      `CHK("unmapped read", 32'h0, d)
      `CHK("above at reset", 8'h00, above)

      // Counter 1: edge counting between limits 2 and 10, flag level 7.
      wr_reg(1, cud_pkg::REG_SEL, sel_w(cud_pkg::M_RISE, 5'd1, 5'd2, 5'd3));
      wr_reg(1, cud_pkg::REG_LIM, {16'h000a, 16'h0002});
      wr_reg(1, cud_pkg::REG_STEP, {16'h0003, 16'h0001});
      wr_reg(1, cud_pkg::REG_FLAG, 32'h00000007);
      chk_val(1, 16'h0002);
      for (int i = 0; i < 8; i++)
      begin
         pulse(ev[i], 3);
         chk_val(1, ex[i]);
         `CHK("above flag", abv[i], above[1])
      end
      sg(3, 1'b1);
      pulse(1, 3);
      chk_val(1, 16'h0002);
      sg(3, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         wr_reg(1, cud_pkg::REG_SEL, sel_w(md[i], 5'd1, 5'd2, 5'd3));
         pulse(3, 2);
         sg(1, 1'b1);
         chk_val(1, mid[i]);
         sg(1, 1'b0);
         chk_val(1, fin[i]);
      end
      // Down source in falling-edge mode, then a code that must not count at all.
      wr_reg(1, cud_pkg::REG_SEL, sel_w(cud_pkg::M_FALL, 5'd1, 5'd2, 5'd3));
      sg(2, 1'b1);
      chk_val(1, 16'h0008);
      sg(2, 1'b0);
      chk_val(1, 16'h0005);
      wr_reg(1, cud_pkg::REG_SEL, sel_w(3'h6, 5'd1, 5'd2, 5'd3));
      pulse(1, 2);
      chk_val(1, 16'h0005);

      // Counter 2: level counting, hold of two ticks, repeat every tick.
      wr_reg(2, cud_pkg::REG_STEP, {16'h0100, 16'h0001});
      wr_reg(2, cud_pkg::REG_TIME, {16'h0001, 16'h0002});
      wr_reg(2, cud_pkg::REG_SEL, sel_w(cud_pkg::M_HIGH, 5'd4, 5'd5, 5'd6));
      sg(4, 1'b1);
      chk_val(2, 16'h0001);
      repeat (40) @(posedge clock);
      sg(4, 1'b0);
      rd_reg(2, cud_pkg::REG_STAT, d);
      `CHK("tap once", 8'h01, d[7:0])
      `CHK("repeats", 1'b1, d[15:0] >= 16'h0301)
      repeat (20) @(posedge clock);
      chk_val(2, d[15:0]);
      wr_reg(2, cud_pkg::REG_SEL, sel_w(cud_pkg::M_LOW, 5'd4, 5'd5, 5'd6));
      sg(5, 1'b1);
      sg(4, 1'b1);
      pulse(6, 2);
      chk_val(2, 16'h0000);
      sg(4, 1'b0);
      chk_val(2, 16'h0001);

      // Counter 3: toggle and ramp between 0 and 4, long press of four ticks.
      wr_reg(3, cud_pkg::REG_LIM, {16'h0004, 16'h0000});
      wr_reg(3, cud_pkg::REG_STEP, {16'h0002, 16'h0001});
      wr_reg(3, cud_pkg::REG_TIME, {16'h0001, 16'h0004});
      wr_reg(3, cud_pkg::REG_SEL, sel_w(cud_pkg::M_TOG, 5'd7, 5'd8, 5'd0));
      pulse(7, 0);
      `CHK("load on", 1'b1, load_on[3])
      pulse(7, 0);
      `CHK("load off", 1'b0, load_on[3])
      pulse(8, 30);
      chk_val(3, 16'h0000);
      for (int i = 0; i < 5; i++)
      begin
         pulse(7, 30);
         chk_val(3, tv[i]);
         `CHK("ramp down", tdir[i], d[cud_pkg::S_DESC])
      end
      `CHK("load after ramp", 1'b0, load_on[3])
      chk_val(0, 16'h0000);
      results();
   end
endmodule
